// [logic/adc_conversion_sequencer.sv]
`timescale 1ns/1ps

module adc_conversion_sequencer
	import adc_seq_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// pins from the card and converter
	input wire logic read_pending_n_i,
	input wire logic pace_hold_i,
	input wire logic [LSB_W-1:0] conv_data_i,
	input wire logic polarity_i,
	input wire logic common_overrange_n_i,
	// converter control
	output logic sys_clk_o,
	output logic conv_cs_n_o,
	output logic conv_write_n_buf_o,
	output logic conv_read_n_buf_o,
	output logic conv_ctl_data_n_buf_o,
	output logic [MODE_W-1:0] mode_data_o,
	output logic mode_data_oe_o,
	// analog and card control
	output logic sample_ctl_buf_o,
	output logic latch_strobe_o,
	output logic latch_strobe_buf_o,
	output logic pacing_enable_o,
	output logic wait_o,
	output logic run_o,
	output logic [4:0] step_o,
	// result
	output logic [WORD_W-1:0] data_word_o,
	output logic data_valid_o
);

	// ----------------------------------------------------------------
	// control table
	// ----------------------------------------------------------------
	// one entry per step; outside listed steps strobes sit idle
	function automatic ctl_s lookup(input logic [4:0] step);
		ctl_s c;
		c = CTL_IDLE;
		c.wait_flag = (step == STEP_WAIT);
		// tracking from sampling start up to the hold step
		c.sample = (step >= STEP_SAMPLE) && (step < STEP_HOLD);
		// upper nibble read spans sample start
		if ((step >= STEP_RD_HI) && (step < STEP_RD_END)) begin
			c.read_n = 1'b0;
		end
		// ctl/data low with read low gives the lower byte
		if ((step >= STEP_RD_LO) && (step < STEP_CD_END)) begin
			c.ctl_data_n = 1'b0;
		end
		c.latch = (step == STEP_LATCH_A) || (step == STEP_HOLD);
		// write low alone programs the mode
		if (step == STEP_MODE) begin
			c.write_n = 1'b0;
		end
		c.pace_en = (step == STEP_PACE);
		if (step == STEP_CONV_CD) begin
			c.ctl_data_n = 1'b0;
		end
		// both low together starts the conversion
		if (step == STEP_CONV) begin
			c.ctl_data_n = 1'b0;
			c.write_n = 1'b0;
		end
		c.restart = (step == STEP_RESTART);
		return c;
	endfunction : lookup

	// ----------------------------------------------------------------
	// system clock divider
	// ----------------------------------------------------------------
	logic [6:0] div_reg; // ref cycles into the step
	logic [6:0] div_next;
	logic sys_clk_reg; // square wave to converter
	logic sys_clk_next;
	logic rise_tick; // system clock rising edge
	logic fall_tick; // system clock falling edge

	// ticks are one ref cycle wide; step logic keys off them only
	assign rise_tick = (div_reg == DIV_LAST);
	assign fall_tick = (div_reg == DIV_FALL);

	// divider wraps every 600 ns step
	always_comb begin
		div_next = rise_tick ? 7'h00 : div_reg + 7'h01;
		sys_clk_next = sys_clk_reg;
		if (rise_tick) begin
			sys_clk_next = 1'b1;
		end else if (fall_tick) begin
			sys_clk_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_reg <= 7'h00;
			sys_clk_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			sys_clk_reg <= sys_clk_next;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// data, polarity, overrange, read pending, pace hold
	localparam int SYNC_W = LSB_W + 4;
	logic [SYNC_W-1:0] sync1_reg; // first stage, read only by second
	logic [SYNC_W-1:0] sync2_reg; // safe to use
	logic [SYNC_W-1:0] pins_raw;

	assign pins_raw = {pace_hold_i, read_pending_n_i, common_overrange_n_i,
		polarity_i, conv_data_i};

	// pins read low for two cycles after reset; no decision comes
	// that early, so nothing acts on it
	// two flops before any logic looks at a pin
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
		end
	end

	logic [LSB_W-1:0] data_s;
	logic polarity_s; // high for negative input
	logic ovr_n_s; // low on overrange
	logic read_pending_n_s;
	logic pace_hold_s;

	assign data_s = sync2_reg[LSB_W-1:0];
	assign polarity_s = sync2_reg[LSB_W];
	assign ovr_n_s = sync2_reg[LSB_W+1];
	assign read_pending_n_s = sync2_reg[LSB_W+2];
	assign pace_hold_s = sync2_reg[LSB_W+3];

	// ----------------------------------------------------------------
	// sequence counter and table
	// ----------------------------------------------------------------
	logic [4:0] step_reg; // table address
	logic [4:0] step_next;
	ctl_s ctl_reg; // unbuffered table outputs
	ctl_s ctl_next;
	ctl_s buf_reg; // falling-edge copies
	ctl_s buf_next;
	logic run_reg; // stop register, low halts count
	logic run_next;

	// while halted the divider keeps running, so the converter
	// clock never stops
	// counter and lookup move on the rising edge only
	always_comb begin
		step_next = step_reg;
		ctl_next = ctl_reg;
		if (rise_tick && run_reg) begin
			if (ctl_reg.restart) begin
				step_next = STEP_RESET;
			end else begin
				step_next = step_reg + 5'h01;
			end
			ctl_next = lookup(step_next);
		end
	end

	// stop decision and clean copies taken half a step later;
	// the table settles on the rise, so the fall sees no glitch
	always_comb begin
		buf_next = buf_reg;
		run_next = run_reg;
		if (fall_tick) begin
			buf_next = ctl_reg;
			// idle waits for a read; pacing may hold step 15
			run_next = !((ctl_reg.wait_flag && read_pending_n_s) ||
				(ctl_reg.pace_en && pace_hold_s));
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			step_reg <= STEP_RESET;
			ctl_reg <= CTL_IDLE;
			buf_reg <= CTL_IDLE;
			run_reg <= 1'b0;
		end else begin
			step_reg <= step_next;
			ctl_reg <= ctl_next;
			buf_reg <= buf_next;
			run_reg <= run_next;
		end
	end

	// ----------------------------------------------------------------
	// result capture
	// ----------------------------------------------------------------
	ctl_s seen_reg; // buffered copy at the previous rise
	ctl_s seen_next;
	logic [MSB_W-1:0] msb_reg; // upper nibble held
	logic [MSB_W-1:0] msb_next;
	logic sign_reg; // polarity at the hold step
	logic sign_next;
	logic ovr_reg; // overrange at the hold step
	logic ovr_next;
	logic [WORD_W-1:0] word_reg;
	logic [WORD_W-1:0] word_next;
	logic valid_reg;
	logic valid_next;

	// limitation: data and flags both come from the previous pass's conversion,
	// so the first word after reset carries the reset flags
	// rising-edge consumers use the buffered strobes only
	always_comb begin
		seen_next = seen_reg;
		msb_next = msb_reg;
		sign_next = sign_reg;
		ovr_next = ovr_reg;
		word_next = word_reg;
		valid_next = 1'b0;
		if (rise_tick) begin
			seen_next = buf_reg;
			// sampling start also latches the upper nibble
			if (buf_reg.sample && !seen_reg.sample) begin
				msb_next = data_s[MSB_W-1:0];
			end
			// latch while reading: lower byte completes the word
			if (buf_reg.latch && !seen_reg.latch) begin
				if (!buf_reg.read_n) begin
					word_next[LSB_W-1:0] = data_s;
					word_next[LSB_W+MSB_W-1:LSB_W] = msb_reg;
					word_next[SIGN_BIT] = sign_reg;
					word_next[OVR_BIT] = ovr_reg;
					valid_next = 1'b1;
				end else begin
					// latch at hold time freezes the flags
					sign_next = polarity_s;
					ovr_next = ovr_n_s;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			seen_reg <= CTL_IDLE;
			msb_reg <= '0;
			sign_reg <= 1'b0;
			ovr_reg <= 1'b1;
			word_reg <= WORD_RESET;
			valid_reg <= 1'b0;
		end else begin
			seen_reg <= seen_next;
			msb_reg <= msb_next;
			sign_reg <= sign_next;
			ovr_reg <= ovr_next;
			word_reg <= word_next;
			valid_reg <= valid_next;
		end
	end

	// ----------------------------------------------------------------
	// mode data lines
	// ----------------------------------------------------------------
	logic [MODE_W-1:0] mode_reg; // value on the shared lines
	logic [MODE_W-1:0] mode_next;
	logic mode_oe_reg; // drive only while chip is not reading
	logic mode_oe_next;

	// taken from the next buffered value so lines and strobes
	// change on the same ref edge
	// lines follow the inverted buffered read strobe; the driver is
	// off while read is low so the chip owns the bus then
	always_comb begin
		mode_next = {MODE_W{~buf_next.read_n}};
		mode_oe_next = buf_next.read_n;
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg <= '0;
			mode_oe_reg <= 1'b1;
		end else begin
			mode_reg <= mode_next;
			mode_oe_reg <= mode_oe_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all from flops
	// ----------------------------------------------------------------
	logic cs_n_reg; // chip select, never released

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cs_n_reg <= 1'b0;
		end else begin
			cs_n_reg <= 1'b0;
		end
	end

	assign sys_clk_o = sys_clk_reg;
	assign conv_cs_n_o = cs_n_reg;
	assign conv_write_n_buf_o = buf_reg.write_n;
	assign conv_read_n_buf_o = buf_reg.read_n;
	assign conv_ctl_data_n_buf_o = buf_reg.ctl_data_n;
	assign mode_data_o = mode_reg;
	assign mode_data_oe_o = mode_oe_reg;
	// hold stage tracks while high, holds while low
	assign sample_ctl_buf_o = buf_reg.sample;
	// falling-edge users get the raw table output
	assign latch_strobe_o = ctl_reg.latch;
	assign latch_strobe_buf_o = buf_reg.latch;
	assign pacing_enable_o = ctl_reg.pace_en;
	assign wait_o = ctl_reg.wait_flag;
	assign run_o = run_reg;
	assign step_o = step_reg;
	assign data_word_o = word_reg;
	assign data_valid_o = valid_reg;

endmodule : adc_conversion_sequencer

// [logic/adc_seq_pkg.sv]
package adc_seq_pkg;

	// ----------------------------------------------------------------
	// clocking and step timing
	// ----------------------------------------------------------------
	localparam int REF_PERIOD_NS = 8; // reference clock period
	localparam int SYS_PERIOD_NS = 600; // one table step
	localparam int SYS_DIV = SYS_PERIOD_NS / REF_PERIOD_NS; // 75 ref cycles
	localparam int SYS_HALF = SYS_DIV / 2; // falling edge position
	localparam logic [6:0] DIV_LAST = 7'(SYS_DIV - 1);
	localparam logic [6:0] DIV_FALL = 7'(SYS_HALF);

	// converter needs 12.5 system clocks, held here doubled
	localparam int CONV_HALF_CYCLES = 25;
	localparam int CONV_WAIT = (CONV_HALF_CYCLES + 1) / 2; // 13 steps

	// ----------------------------------------------------------------
	// sequence steps
	// ----------------------------------------------------------------
	localparam int STEP_COUNT = 30;
	localparam logic [4:0] STEP_WAIT = 5'h00; // idle, wait flag high
	localparam logic [4:0] STEP_RD_HI = 5'h01; // upper four bits out
	localparam logic [4:0] STEP_SAMPLE = 5'h02; // sampling starts
	localparam logic [4:0] STEP_RD_LO = 5'h03; // lower eight bits out
	localparam logic [4:0] STEP_LATCH_A = 5'h04; // lower byte latched
	localparam logic [4:0] STEP_RD_END = 5'h05; // read strobe released
	localparam logic [4:0] STEP_CD_END = 5'h06; // ctl/data released
	localparam logic [4:0] STEP_MODE = 5'h07; // mode programming
	localparam logic [4:0] STEP_PACE = 5'h0f; // pacing may hold here
	localparam logic [4:0] STEP_CONV_CD = 5'h10; // ctl/data low first
	localparam logic [4:0] STEP_CONV = 5'h11; // conversion start
	localparam logic [4:0] STEP_HOLD = 5'h12; // hold, polarity latched
	localparam logic [4:0] STEP_RESTART =
		5'(int'(STEP_CONV) + CONV_WAIT - 1); // 29
	localparam logic [4:0] STEP_RESET = 5'h00;

	// ----------------------------------------------------------------
	// output data word layout
	// ----------------------------------------------------------------
	localparam int WORD_W = 14;
	localparam int SIGN_BIT = 12;
	localparam int OVR_BIT = 13;
	localparam int MSB_W = 4;
	localparam int LSB_W = 8;
	localparam int MODE_W = 3;
	localparam logic [WORD_W-1:0] WORD_RESET = 14'h0000;

	// ----------------------------------------------------------------
	// one table entry
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sample; // sample-hold tracks while high
		logic write_n; // converter write strobe
		logic read_n; // converter read strobe
		logic ctl_data_n; // converter control/data select
		logic latch; // data latch strobe
		logic pace_en; // pacing may stop the counter
		logic wait_flag; // idle point, waits for a read
		logic restart; // last entry, counter back to zero
	} ctl_s;

	localparam ctl_s CTL_IDLE = '{sample: 1'b0, write_n: 1'b1,
		read_n: 1'b1, ctl_data_n: 1'b1, latch: 1'b0, pace_en: 1'b0,
		wait_flag: 1'b1, restart: 1'b0};

endpackage : adc_seq_pkg

// [tb/adc_conv_model.sv]
`timescale 1ns/1ps
module adc_conv_model
	import adc_seq_pkg::*;
(
	// clock and strobes
	input wire logic ref_clk_i,
	input wire logic write_n_i,
	input wire logic read_n_i,
	input wire logic ctl_data_n_i,
	input wire logic sample_i,
	// analog stand-ins
	input wire logic [11:0] result_i,
	input wire logic negative_i,
	// pins back
	output logic [LSB_W-1:0] data_o,
	output logic polarity_o
);
	logic [11:0] conv_reg = 12'h000; // last conversion
	logic neg_reg = 1'b0; // held polarity
	logic [LSB_W-1:0] last_reg = 8'h00; // last lane value
	// convert on start, track only while sampling
	always @(posedge ref_clk_i) begin
		if (!write_n_i && !ctl_data_n_i) begin
			conv_reg <= result_i;
		end
		if (sample_i) begin
			neg_reg <= negative_i;
		end
		last_reg <= data_o;
	end
	// released lanes toggle so stale data cannot pass
	always_comb begin
		if (read_n_i) begin
			data_o = ~last_reg;
		end else if (ctl_data_n_i) begin
			data_o = {4'h0, conv_reg[11:8]};
		end else begin
			data_o = conv_reg[7:0];
		end
	end
	assign polarity_o = neg_reg;
endmodule : adc_conv_model

// [tb/adc_seq_chk.sv]
`timescale 1ns/1ps
module adc_seq_chk
	import adc_seq_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// watched outputs
	input wire logic sys_clk_o,
	input wire logic conv_cs_n_o,
	input wire logic conv_write_n_buf_o,
	input wire logic conv_read_n_buf_o,
	input wire logic conv_ctl_data_n_buf_o,
	input wire logic [MODE_W-1:0] mode_data_o,
	input wire logic mode_data_oe_o,
	input wire logic sample_ctl_buf_o,
	input wire logic latch_strobe_o,
	input wire logic latch_strobe_buf_o,
	input wire logic pacing_enable_o,
	input wire logic run_o,
	input wire logic [4:0] step_o,
	input wire logic data_valid_o
);
	// ----
	// one domain, so shared clocking
	// ----
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	chk_cs_tied:
	assert property (conv_cs_n_o == 1'b0) else $error("cs high");
	chk_mode_lines:
	assert property (mode_data_oe_o == conv_read_n_buf_o &&
		mode_data_o == {MODE_W{~conv_read_n_buf_o}}) else $error("mode");
	chk_step_advance:
	assert property ($rose(sys_clk_o) && $past(run_o) &&
		$past(step_o) != STEP_RESTART |-> step_o == $past(step_o) + 5'h01)
		else $error("no step");
	chk_step_wrap:
	assert property ($rose(sys_clk_o) && $past(run_o) &&
		$past(step_o) == STEP_RESTART |-> step_o == STEP_RESET)
		else $error("no wrap");
	chk_step_halt:
	assert property (!$rose(sys_clk_o) || !$past(run_o) |-> $stable(step_o))
		else $error("step moved");
	chk_sample_span:
	assert property ($fell(sys_clk_o) |-> sample_ctl_buf_o ==
		(step_o >= STEP_SAMPLE && step_o <= 5'h11)) else $error("sample");
	chk_mode_prog:
	assert property ($fell(sys_clk_o) && step_o == STEP_MODE |->
		!conv_write_n_buf_o && conv_read_n_buf_o && conv_ctl_data_n_buf_o)
		else $error("mode strobes");
	chk_conv_start:
	assert property ($fell(sys_clk_o) && step_o == STEP_CONV |->
		!conv_write_n_buf_o && !conv_ctl_data_n_buf_o) else $error("start");
	chk_read_hi:
	assert property ($fell(sys_clk_o) && step_o == STEP_RD_HI |->
		!conv_read_n_buf_o && conv_write_n_buf_o && conv_ctl_data_n_buf_o)
		else $error("read hi");
	chk_read_lo:
	assert property ($fell(sys_clk_o) && step_o == STEP_RD_LO |->
		!conv_read_n_buf_o && conv_write_n_buf_o && !conv_ctl_data_n_buf_o)
		else $error("read lo");
	chk_buf_half:
	assert property ($changed(latch_strobe_buf_o) |-> $fell(sys_clk_o) &&
		latch_strobe_buf_o == latch_strobe_o) else $error("buffer edge");
	chk_pace_step:
	assert property (pacing_enable_o == (step_o == STEP_PACE))
		else $error("pace enable");
	cov_pace: cover property (pacing_enable_o && !run_o);
	cov_word: cover property (data_valid_o);
	cov_conv: cover property (!conv_write_n_buf_o && !conv_ctl_data_n_buf_o);
endmodule : adc_seq_chk

bind adc_conversion_sequencer adc_seq_chk adc_seq_chk_i (.ref_clk_i,
	.arst_n_i, .sys_clk_o, .conv_cs_n_o, .conv_write_n_buf_o,
	.conv_read_n_buf_o, .conv_ctl_data_n_buf_o, .mode_data_o,
	.mode_data_oe_o, .sample_ctl_buf_o, .latch_strobe_o,
	.latch_strobe_buf_o, .pacing_enable_o, .run_o, .step_o, .data_valid_o);

// [tb/test_adc_conversion_sequencer.sv]
`timescale 1ns/1ps
module test_adc_conversion_sequencer import adc_seq_pkg::*;;
	// ----
	// pins and counters
	// ----
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic pend_n = 1'b1;
	logic hold = 1'b0;
	logic ovr_n = 1'b1;
	logic neg = 1'b0;
	logic [11:0] res = 12'h000;
	logic [LSB_W-1:0] cdata;
	logic pol, sclk, wr_n, rd_n, cd_n, smp, wt, run, valid;
	logic [4:0] step;
	logic [WORD_W-1:0] word;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	adc_conversion_sequencer adc_conversion_sequencer_i (.ref_clk_i,
		.arst_n_i, .read_pending_n_i(pend_n), .pace_hold_i(hold),
		.conv_data_i(cdata), .polarity_i(pol), .common_overrange_n_i(ovr_n),
		.sys_clk_o(sclk), .conv_cs_n_o(), .conv_write_n_buf_o(wr_n),
		.conv_read_n_buf_o(rd_n), .conv_ctl_data_n_buf_o(cd_n),
		.mode_data_o(), .mode_data_oe_o(), .sample_ctl_buf_o(smp),
		.latch_strobe_o(), .latch_strobe_buf_o(), .pacing_enable_o(),
		.wait_o(wt), .run_o(run), .step_o(step), .data_word_o(word),
		.data_valid_o(valid));
	adc_conv_model adc_conv_model_i (.ref_clk_i, .write_n_i(wr_n),
		.read_n_i(rd_n), .ctl_data_n_i(cd_n), .sample_i(smp), .result_i(res),
		.negative_i(neg), .data_o(cdata), .polarity_o(pol));
	// one compare for every result
	task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic steps(input int n);
		repeat (n * SYS_DIV) @(posedge ref_clk_i);
		#1;
	endtask : steps
	// bounded wait for the word pulse
	task automatic wait_valid(output int n);
		n = 0;
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while (valid !== 1'b1 && n < 5000);
		// a word that never comes counts against the run
		if (valid !== 1'b1) begin
			errors++;
			$display("unexpected at %0t: no data word", $time);
		end
	endtask : wait_valid
	task automatic t_reset();
		cmp({4'h0, run, wt, wr_n, rd_n, cd_n, step}, 14'h01e0);
		cmp(word, WORD_RESET);
	endtask : t_reset
	// no read waiting keeps the counter at zero
	task automatic t_idle();
		steps(4);
		cmp({8'h00, run, step}, 14'h0000);
	endtask : t_idle
	// values set now show in the second word
	task automatic t_convert(input logic [11:0] r, input logic n, o);
		int n1;
		res = r;
		neg = n;
		ovr_n = o;
		pend_n = 1'b0;
		wait_valid(n1);
		wait_valid(n1);
		cmp(word, {o, n, r});
		cmp(14'(n1), 14'(STEP_COUNT * SYS_DIV));
	endtask : t_convert
	// pacing hold stops at fifteen only
	task automatic t_pace();
		int n;
		hold = 1'b1;
		n = 0;
		while (step !== STEP_PACE && n < 5000) begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end
		steps(3);
		cmp({9'h000, step}, {9'h000, STEP_PACE});
		hold = 1'b0;
		steps(2);
		cmp({13'h0000, step == 5'h10 || step == 5'h11}, 14'h0001);
	endtask : t_pace
	// reset in mid-run: back to a halted step 0
	task automatic t_rerun();
		arst_n_i = 1'b0;
		pend_n = 1'b1;
		steps(2);
		t_reset();
		arst_n_i = 1'b1;
		t_idle();
	endtask : t_rerun
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	// cut a hang short
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk_i);
		#1;
		t_reset();
		arst_n_i = 1'b1;
		t_idle();
		t_convert(12'hfff, 1'b1, 1'b0);
		t_convert(12'h000, 1'b0, 1'b1);
		t_convert(12'ha5c, 1'b1, 1'b1);
		t_pace();
		t_rerun();
		end_of_test();
	end
endmodule : test_adc_conversion_sequencer
